// ==== hw/smsd_top.sv ====
// supervisor and memory-access decoder of a secure microcontroller module
// assumes cpu core outside issues one access at a time and waits for done
`timescale 1ns/1ps
// Function
// RL1 - high reset input holds device in reset
// RL2 - reset input pulled down when floating
// RL3 - falling bootstrap request starts loader
// RL4 - bootstrap held low at power-up enters loader
// RL5 - far side debounces bootstrap request
// RL6 - self-destruct erases keys, drops memory power
// RL7 - far side grounds unused self-destruct
// RL8 - low port open-drain as gpio, push-pull bus
// RL9 - high port carries upper address byte
// RL10 - latch strobe captures low address byte
// RL11 - active-low write strobe during writes
// RL12 - active-low read strobe during reads
// RL13 - irq zero shared with clock-calendar output
// RL14 - irq one active-low request
// RL15 - default mode: all on internal bus
// RL16 - partitioned unmapped data goes expanded
// RL17 - program fetch never uses expanded bus
// RL18 - peripheral select steers data to clock
// RL19 - warning threshold vectors to 2Bh
// RL20 - reset threshold suspends execution
// RL21 - supply reset forces enables inactive high
// RL22 - below backup threshold switch to cell
// RL23 - leave reset only when both clear
module smsd_top import smsd_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic reset_pin_driven,
    input wire logic bootstrap_request,
    input wire logic bootstrap_request_driven,
    input wire logic self_destruct_input,
    input wire logic below_warning_threshold,
    input wire logic below_reset_threshold,
    input wire logic below_backup_threshold,
    input wire logic pfw_enable,
    input wire logic ext_irq_zero,
    input wire logic clock_calendar_irq_out,
    input wire logic ext_irq_one,
    input wire logic partition_mode,
    input wire logic [15:0] partition_addr,
    input wire logic peripheral_space_select,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_fetch,
    input wire logic [15:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic [7:0] gpio_p0_out,
    input wire logic [7:0] low_addr_data_port_in,
    output logic [7:0] low_addr_data_port_out,
    output logic [7:0] low_addr_data_port_oe,
    output logic [7:0] high_addr_port,
    output logic addr_latch_enable,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic acc_done,
    output logic [7:0] acc_rdata,
    output logic nvram_ce_n,
    output logic rtc_ce_n,
    output logic mem_rw_n,
    output logic cpu_reset,
    output logic bootstrap_start,
    output logic bootstrap_mode,
    output logic pfw_irq,
    output logic [15:0] pfw_vector,
    output logic irq0_req,
    output logic irq1_req,
    output logic key_erase,
    output logic switched_memory_supply_en,
    output logic battery_backup
);
    logic rst_pin_s, rst_drv_s, boot_s, boot_drv_s, sdi_s;
    logic pfw_s, vmin_s, vli_s, ext_irq_zero_s, clock_calendar_irq_out_s, ext_irq_one_s;
    logic boot_level, boot_fall, rst_level, reset_hold;
    logic pfw_prev_q, boot_seen_q, unlock_busy;
    logic [11:0] unlock_cnt_q;
    smsd_bus_state_t bus_q;
    smsd_target_t tgt;
    logic [2:0] strobe_cnt_q;
    logic wr_q, exp_active;
    logic [15:0] addr_q;
    logic [7:0] wdata_q, rdata_q;
    logic done_q;

    // each reset, bootstrap, self-destruct, threshold and irq pin level passes two flops before any logic looks at it
    smsd_sync #(.RST_VAL(1'b0)) u_s_rst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(reset_pin),
        .level_out(rst_pin_s)
    );

    smsd_sync #(.RST_VAL(1'b0)) u_s_rstd (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(reset_pin_driven),
        .level_out(rst_drv_s)
    );

    smsd_sync #(.RST_VAL(1'b1)) u_s_boot (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(bootstrap_request),
        .level_out(boot_s)
    );

    smsd_sync #(.RST_VAL(1'b0)) u_s_bootd (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(bootstrap_request_driven),
        .level_out(boot_drv_s)
    );

    smsd_sync #(.RST_VAL(1'b0)) u_s_sdi (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(self_destruct_input),
        .level_out(sdi_s)
    );

    smsd_sync #(.RST_VAL(1'b0)) u_s_pfw (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(below_warning_threshold),
        .level_out(pfw_s)
    );

    // supply assumed low until the first real samples arrive
    smsd_sync #(.RST_VAL(1'b1)) u_s_vmin (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(below_reset_threshold),
        .level_out(vmin_s)
    );

    smsd_sync #(.RST_VAL(1'b0)) u_s_vli (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(below_backup_threshold),
        .level_out(vli_s)
    );

    smsd_sync #(.RST_VAL(1'b1)) u_s_ext_irq_zero (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(ext_irq_zero),
        .level_out(ext_irq_zero_s)
    );

    smsd_sync #(.RST_VAL(1'b1)) u_s_clock_calendar_irq_out (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(clock_calendar_irq_out),
        .level_out(clock_calendar_irq_out_s)
    );

    smsd_sync #(.RST_VAL(1'b1)) u_s_ext_irq_one (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(ext_irq_one),
        .level_out(ext_irq_one_s)
    );

    // RL2 pull-down: undriven reset pin reads inactive
    assign rst_level = rst_drv_s & rst_pin_s;
    // RL4 pull-up: undriven bootstrap pin reads high
    assign boot_level = boot_drv_s ? boot_s : 1'b1;

    smsd_edge u_boot_edge (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level_in(boot_level),
        .fall_pulse(boot_fall)
    );

    // RL1 RL20 reset sources
    // RL23 release needs both clear
    assign reset_hold = rst_level | vmin_s;
    assign cpu_reset = reset_hold;

    // RL3 bootstrap on falling edge
    // RL5 one edge per request is assumed debounced outside
    assign bootstrap_start = boot_fall & ~reset_hold;

    // RL4 low level at reset release selects loader
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bootstrap_mode <= 1'b0;
            boot_seen_q <= 1'b0;
        end else if (reset_hold) begin
            boot_seen_q <= 1'b0;
        end else if (!boot_seen_q) begin
            boot_seen_q <= 1'b1;
            bootstrap_mode <= ~boot_level;
        end else if (boot_fall) begin
            bootstrap_mode <= 1'b1;
        end
    end

    // RL6 self-destruct unlock and supply dropout
    // RL7 input assumed grounded when unused
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            unlock_cnt_q <= 12'h000;
        end else if (sdi_s) begin
            unlock_cnt_q <= SMSD_UNLOCK_CNT;
        end else if (unlock_cnt_q != 12'h000) begin
            unlock_cnt_q <= unlock_cnt_q - 12'h001;
        end
    end
    assign unlock_busy = unlock_cnt_q != 12'h000;
    assign key_erase = sdi_s;
    // RL22 backup cell keeps memory but no vcc path
    assign switched_memory_supply_en = ~unlock_busy;
    assign battery_backup = vli_s;

    // RL19 warning vectors to 2Bh, execution continues
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pfw_prev_q <= 1'b0;
        end else begin
            pfw_prev_q <= pfw_s;
        end
    end
    assign pfw_irq = pfw_s & ~pfw_prev_q & pfw_enable & ~reset_hold;
    assign pfw_vector = SMSD_PFW_VECTOR;

    // RL13 shared low-active line with clock-calendar
    assign irq0_req = ~(ext_irq_zero_s & clock_calendar_irq_out_s);
    // RL14 low-active external request one
    assign irq1_req = ~ext_irq_one_s;

    // target decode; fetches never leave the module
    always_comb begin
        // RL15 default: everything internal
        tgt = SMSD_TGT_NVRAM;
        // RL17 fetches stay internal
        if (acc_fetch) begin
            tgt = SMSD_TGT_NVRAM;
        // RL18 peripheral space to clock
        end else if (peripheral_space_select) begin
            tgt = SMSD_TGT_RTC;
        // RL16 at or above partition goes expanded
        end else if (partition_mode && acc_addr >= partition_addr) begin
            tgt = SMSD_TGT_EXP;
        end
    end

    assign exp_active = bus_q != SMSD_BUS_IDLE;

    // expanded bus cycle sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n || reset_hold) begin
            bus_q <= SMSD_BUS_IDLE;
            strobe_cnt_q <= SMSD_SYNC_ZERO;
            wr_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else begin
            unique case (bus_q)
                SMSD_BUS_IDLE: begin
                    if (acc_req && tgt == SMSD_TGT_EXP) begin
                        bus_q <= SMSD_BUS_ADDR;
                        wr_q <= acc_write;
                        addr_q <= acc_addr;
                        wdata_q <= acc_wdata;
                    end
                end
                SMSD_BUS_ADDR: begin
                    bus_q <= SMSD_BUS_LATCH;
                end
                SMSD_BUS_LATCH: begin
                    bus_q <= SMSD_BUS_STROBE;
                    strobe_cnt_q <= SMSD_STROBE_CYC;
                end
                SMSD_BUS_STROBE: begin
                    strobe_cnt_q <= strobe_cnt_q - 3'h1;
                    if (strobe_cnt_q == 3'h1) begin
                        bus_q <= SMSD_BUS_HOLD;
                    end
                end
                SMSD_BUS_HOLD: begin
                    bus_q <= SMSD_BUS_IDLE;
                end
                default: begin
                    bus_q <= SMSD_BUS_IDLE;
                end
            endcase
        end
    end

    // read data is captured on the last strobe cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (bus_q == SMSD_BUS_STROBE && strobe_cnt_q == 3'h1 && !wr_q) begin
            rdata_q <= low_addr_data_port_in;
        end
    end

    // internal accesses complete in one cycle, expanded in the cycle after hold
    always_ff @(posedge sys_clk) begin
        if (!rst_n || reset_hold) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (acc_req && !exp_active && tgt != SMSD_TGT_EXP && !done_q)
                || bus_q == SMSD_BUS_HOLD;
        end
    end
    assign acc_done = done_q;
    assign acc_rdata = rdata_q;

    // RL10 latch strobe high in the first of the two low-port address cycles
    assign addr_latch_enable = bus_q == SMSD_BUS_ADDR;
    // RL11 write strobe low in strobe phase
    assign write_strobe_n = ~(bus_q == SMSD_BUS_STROBE && wr_q);
    // RL12 read strobe low in strobe phase
    assign read_strobe_n = ~(bus_q == SMSD_BUS_STROBE && !wr_q);

    // RL9 upper address byte on high port
    assign high_addr_port = exp_active ? addr_q[15:8] : SMSD_PORT_IDLE;

    // RL8 gpio open-drain, bus push-pull
    always_comb begin
        low_addr_data_port_out = 8'h00;
        low_addr_data_port_oe = ~gpio_p0_out;
        if (bus_q == SMSD_BUS_ADDR || bus_q == SMSD_BUS_LATCH) begin
            // RL10 low address byte multiplexed
            low_addr_data_port_out = addr_q[7:0];
            low_addr_data_port_oe = SMSD_PORT_IDLE;
        end else if (exp_active && wr_q) begin
            low_addr_data_port_out = wdata_q;
            low_addr_data_port_oe = SMSD_PORT_IDLE;
        end else if (exp_active) begin
            low_addr_data_port_oe = 8'h00;
        end
    end

    // RL21 supply reset forces enables high
    assign nvram_ce_n = vmin_s | ~(acc_req && !exp_active && tgt == SMSD_TGT_NVRAM);
    assign rtc_ce_n = vmin_s | ~(acc_req && !exp_active && tgt == SMSD_TGT_RTC);
    assign mem_rw_n = vmin_s | ~(acc_req && acc_write && !exp_active
        && tgt != SMSD_TGT_EXP && !acc_fetch);
endmodule

// ==== hw/smsd_pkg.sv ====
// constants shared by the supervisor/decoder block and its helpers
// assumes a single 250 MHz system clock and synchronous active-low reset
package smsd_pkg;
    localparam int unsigned SMSD_CLK_MHZ = 250;
    // hardware unlock removes switched memory power for this long
    localparam int unsigned SMSD_UNLOCK_US = 10;
    localparam int unsigned SMSD_UNLOCK_CYC = SMSD_UNLOCK_US * SMSD_CLK_MHZ;
    localparam logic [11:0] SMSD_UNLOCK_CNT = 12'(SMSD_UNLOCK_CYC);
    localparam logic [15:0] SMSD_PFW_VECTOR = 16'h002B;
    localparam logic [7:0] SMSD_PORT_IDLE = 8'hFF;
    localparam logic [2:0] SMSD_SYNC_ZERO = 3'h0;

    typedef enum logic [2:0] {
        SMSD_BUS_IDLE = 3'b000,
        SMSD_BUS_ADDR = 3'b001,
        SMSD_BUS_LATCH = 3'b010,
        SMSD_BUS_STROBE = 3'b011,
        SMSD_BUS_HOLD = 3'b100
    } smsd_bus_state_t;

    typedef enum logic [1:0] {
        SMSD_TGT_NVRAM = 2'b00,
        SMSD_TGT_RTC = 2'b01,
        SMSD_TGT_EXP = 2'b10,
        SMSD_TGT_NONE = 2'b11
    } smsd_target_t;

    // number of bus-state cycles the strobe stays low
    localparam logic [2:0] SMSD_STROBE_CYC = 3'h3;
endpackage

// ==== hw/smsd_sync.sv ====
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to sys_clk; reset value given by parameter
`timescale 1ns/1ps
module smsd_sync import smsd_pkg::*; #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic level_out
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign level_out = sync_q;
endmodule

// ==== hw/smsd_edge.sv ====
// falling-edge detector on an already synchronised level
// assumes the input is in the sys_clk domain
`timescale 1ns/1ps
module smsd_edge import smsd_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic level_in,
    output logic fall_pulse
);
    logic prev_q;

    // reset to high so a level already low after reset is seen as a falling edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level_in;
        end
    end

    assign fall_pulse = prev_q & ~level_in;
endmodule

// ==== sim/smsd_top_sva.sv ====
// port assertions for the supervisor/decoder
// assumes binding into smsd_top, one clock domain
`timescale 1ns/1ps
module smsd_top_sva import smsd_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic reset_pin_driven,
    input wire logic below_reset_threshold,
    input wire logic clock_calendar_irq_out,
    input wire logic ext_irq_one,
    input wire logic partition_mode,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_fetch,
    input wire logic [15:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic [7:0] low_addr_data_port_out,
    input wire logic [7:0] low_addr_data_port_oe,
    input wire logic [7:0] high_addr_port,
    input wire logic addr_latch_enable,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic nvram_ce_n,
    input wire logic rtc_ce_n,
    input wire logic mem_rw_n,
    input wire logic cpu_reset,
    input wire logic pfw_irq,
    input wire logic [15:0] pfw_vector,
    input wire logic irq0_req,
    input wire logic irq1_req,
    input wire logic key_erase,
    input wire logic switched_memory_supply_en
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_low(sig);
        (!sig)[*3] ##1 sig;
    endsequence
    AST_PIN_RESET: assert property (
        (reset_pin && reset_pin_driven)[*3] |-> cpu_reset) else $error("pin reset lost");
    AST_PIN_FLOAT: assert property (
        (!reset_pin_driven && !below_reset_threshold)[*3] |-> !cpu_reset) else $error("stuck reset");
    AST_SUPPLY_CE: assert property (
        below_reset_threshold[*3] |-> cpu_reset && nvram_ce_n && rtc_ce_n && mem_rw_n)
        else $error("enables active in low supply");
    AST_ALE_ADDR: assert property (
        $rose(addr_latch_enable) |-> low_addr_data_port_oe == 8'hFF
        && low_addr_data_port_out == acc_addr[7:0] && high_addr_port == acc_addr[15:8]
        ##1 !addr_latch_enable) else $error("bad address phase");
    AST_RD_STROBE: assert property (
        $fell(read_strobe_n) |-> !acc_write && low_addr_data_port_oe == 8'h00
        ##0 s_low(read_strobe_n)) else $error("bad read strobe");
    AST_WR_STROBE: assert property (
        $fell(write_strobe_n) |-> acc_write ##0 s_low(write_strobe_n))
        else $error("bad write strobe");
    AST_WR_DATA: assert property (
        $fell(write_strobe_n) |-> (acc_write && low_addr_data_port_oe == 8'hFF
        && low_addr_data_port_out == acc_wdata)[*4]) else $error("write data not held");
    AST_NO_FETCH: assert property (
        acc_req && acc_fetch |=> !addr_latch_enable && read_strobe_n) else $error("fetch went out");
    AST_DEFAULT_INT: assert property (
        acc_req && !partition_mode |=> !addr_latch_enable && read_strobe_n && write_strobe_n)
        else $error("default mode used bus");
    AST_GPIO_OD: assert property (
        !acc_req |-> (low_addr_data_port_out & low_addr_data_port_oe) == 8'h00)
        else $error("gpio drove high");
    AST_IRQ0: assert property (
        (!clock_calendar_irq_out)[*3] |-> irq0_req) else $error("calendar irq lost");
    AST_IRQ1: assert property (
        (!ext_irq_one)[*3] |-> irq1_req) else $error("irq one lost");
    AST_PFW_VEC: assert property (
        pfw_irq |-> pfw_vector == 16'h002B && !cpu_reset) else $error("bad warning vector");
    AST_SDI_OFF: assert property (
        $fell(key_erase) |=> (!switched_memory_supply_en)[*8]) else $error("supply back early");
endmodule
bind smsd_top smsd_top_sva u_sva (.*);

// ==== sim/smsd_bus_partner.sv ====
// byte memory behind an external transparent address latch
// assumes the bench resolves each port bit from the dut output enable alone
`timescale 1ns/1ps
module smsd_bus_partner (
    input wire logic sys_clk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] bus,
    output logic [7:0] drv
);
    logic [7:0] mem_q [256];
    logic [7:0] lat_q;
    logic [7:0] last_q = 8'h00;
    always_latch begin
        if (ale) begin
            lat_q <= bus;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!wr_n) begin
            mem_q[lat_q] <= bus;
        end
        last_q <= bus;
    end
    // released bus toggles so a stale value never reads as valid
    assign drv = rd_n ? ~last_q : mem_q[lat_q];
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the supervisor/decoder
// assumes the partner model stands on the expanded bus
`timescale 1ns/1ps
module testbench import smsd_pkg::*;;
    logic sys_clk = 0, rst_n = 0, reset_pin = 0, reset_pin_driven = 1, bootstrap_request = 1;
    logic bootstrap_request_driven = 1, self_destruct_input = 0, below_warning_threshold = 0;
    logic below_reset_threshold = 0, below_backup_threshold = 0, pfw_enable = 0;
    logic ext_irq_zero = 1, clock_calendar_irq_out = 1, ext_irq_one = 1, partition_mode = 0;
    logic peripheral_space_select = 0, acc_req = 0, acc_write = 0, acc_fetch = 0, nv, rt;
    logic [15:0] partition_addr = 16'h8000, acc_addr = 16'h0000, pfw_vector;
    logic [7:0] acc_wdata = 8'h00, gpio_p0_out = 8'hFF, low_addr_data_port_in, drv, acc_rdata;
    logic [7:0] low_addr_data_port_out, low_addr_data_port_oe, high_addr_port;
    logic addr_latch_enable, write_strobe_n, read_strobe_n, acc_done, nvram_ce_n, rtc_ce_n;
    logic mem_rw_n, cpu_reset, bootstrap_start, bootstrap_mode, pfw_irq, irq0_req, irq1_req;
    logic key_erase, switched_memory_supply_en, battery_backup;
    int n_fail = 0, checks = 0, lat;
    always #2 sys_clk = ~sys_clk;
    assign low_addr_data_port_in = (low_addr_data_port_oe & low_addr_data_port_out)
        | (~low_addr_data_port_oe & drv);
    smsd_top dut (.*);
    smsd_bus_partner u_mem (.sys_clk(sys_clk), .ale(addr_latch_enable), .rd_n(read_strobe_n),
        .wr_n(write_strobe_n), .bus(low_addr_data_port_in), .drv(drv));
    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic bound(input int lim);
        if (lat >= lim) begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic acc(input logic w, input logic f, input logic [15:0] a, input logic [7:0] d);
        tick(1);
        {acc_req, acc_write, acc_fetch, acc_addr, acc_wdata} = {1'b1, w, f, a, d};
        lat = 0;
        // lat counts edges from the request to the visible done pulse
        while (acc_done !== 1'b1 && lat < 40) begin
            tick(1);
            lat++;
            if (lat == 1) {nv, rt} = {nvram_ce_n, rtc_ce_n};
        end
        bound(40);
        acc_req = 0;
    endtask
    task automatic sc_access;
        acc(0, 0, 16'hF000, 8'h00);
        chk({lat[7:0], 6'h0, nv, rt}, 16'h0101);
        partition_mode = 1;
        acc(0, 0, 16'h7FFF, 8'h00);
        chk({lat[7:0], 6'h0, nv, rt}, 16'h0101);
        acc(1, 0, 16'h8000, 8'hA5);
        chk({lat[7:0], 6'h0, nv, rt}, 16'h0703);
        acc(1, 0, 16'h80FF, 8'h3C);
        acc(0, 0, 16'h8000, 8'h00);
        chk({lat[7:0], acc_rdata}, 16'h07A5);
        acc(0, 1, 16'h9000, 8'h00);
        chk({lat[7:0], 6'h0, nv, rt}, 16'h0101);
        peripheral_space_select = 1;
        acc(0, 0, 16'h0010, 8'h00);
        chk({lat[7:0], 6'h0, nv, rt}, 16'h0102);
        peripheral_space_select = 0;
    endtask
    task automatic sc_power;
        pfw_enable = 1;
        below_warning_threshold = 1;
        lat = 0;
        while (pfw_irq !== 1'b1 && lat < 8) begin
            tick(1);
            lat++;
        end
        bound(8);
        chk(pfw_vector, 16'h002B);
        chk(cpu_reset, 0);
        below_reset_threshold = 1;
        tick(4);
        // an internal write, so nvram_ce_n and mem_rw_n would be active without the supply gate
        {acc_req, acc_write} = 2'b11;
        tick(2);
        chk({cpu_reset, nvram_ce_n, rtc_ce_n, mem_rw_n}, 16'hF);
        {acc_req, acc_write} = 2'b00;
        below_backup_threshold = 1;
        reset_pin = 1;
        tick(4);
        chk(battery_backup, 1);
        {below_backup_threshold, below_reset_threshold, below_warning_threshold} = 3'h0;
        tick(4);
        chk(cpu_reset, 1);
        reset_pin_driven = 0;
        tick(4);
        chk(cpu_reset, 0);
    endtask
    task automatic sc_pins;
        logic [2:0] pin [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
        logic [1:0] exp [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
        for (int i = 0; i < 4; i++) begin
            {ext_irq_zero, clock_calendar_irq_out, ext_irq_one} = pin[i];
            tick(4);
            chk({irq0_req, irq1_req}, exp[i]);
        end
        lat = 0;
        bootstrap_request = 0;
        while (bootstrap_start !== 1'b1 && lat < 8) begin
            tick(1);
            lat++;
        end
        bound(8);
        chk(lat, 2);
        tick(1);
        chk(bootstrap_start, 0);
        rst_n = 0;
        tick(3);
        rst_n = 1;
        tick(3);
        chk(bootstrap_mode, 1);
        bootstrap_request_driven = 0;
        rst_n = 0;
        tick(3);
        rst_n = 1;
        tick(3);
        chk(bootstrap_mode, 0);
        // held low apart from this pulse
        self_destruct_input = 1;
        tick(4);
        chk({key_erase, switched_memory_supply_en}, 2);
        self_destruct_input = 0;
        lat = 0;
        while (switched_memory_supply_en !== 1'b1 && lat < 3000) begin
            tick(1);
            lat++;
        end
        bound(3000);
        chk(lat >= 2500 && lat <= 2506, 1);
    endtask
    initial begin
        tick(3);
        rst_n = 1;
        tick(3);
        sc_access();
        sc_power();
        sc_pins();
        wrap_up();
    end
endmodule
